// ---- odd_mode_pkg.sv ----
/*
  Shared constants for the mode page logic: bus map, field positions, page layout,
  defaults, masks, sense keys and the command state type.
  Assumes byte-addressed Avalon-MM with one 32-bit word per register.
*/
`default_nettype none
package odd_mode_pkg;
    // bus map
    localparam logic [4:0] A_CMD = 5'h00;
    localparam logic [4:0] A_STAT = 5'h04;
    localparam logic [4:0] A_BUF = 5'h08;
    localparam logic [4:0] A_ERRPG = 5'h0C;
    localparam logic [4:0] A_FLEX0 = 5'h10;
    localparam logic [4:0] A_FLEX1 = 5'h14;
    localparam logic [4:0] A_FLEX2 = 5'h18;
    localparam logic [4:0] A_EVST = 5'h1C;
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_FMT_BIT = 1;
    localparam int CMD_SAV_BIT = 2;
    localparam int CMD_LEN_LSB = 8;
    localparam int BUF_IDX_LSB = 8;
    // parameter list layout: 8-byte header, then one page descriptor
    localparam logic [7:0] B_MDL0 = 8'h00;
    localparam logic [7:0] B_MDL1 = 8'h01;
    localparam logic [7:0] B_CODE = 8'h08;
    localparam logic [7:0] B_PLEN = 8'h09;
    localparam logic [7:0] B_FLAGS = 8'h0A;
    localparam logic [7:0] B_RRC = 8'h0B;
    localparam logic [7:0] B_WRC = 8'h10;
    localparam logic [7:0] B_PARAM = 8'h0A;
    localparam logic [7:0] FETCH_MAX = 8'h28;
    localparam logic [5:0] PG_ERR = 6'h01;
    localparam logic [7:0] PG_ERR_LEN = 8'h0A;
    localparam logic [5:0] PG_FLEX = 6'h05;
    localparam logic [7:0] PG_FLEX_LEN = 8'h1E;
    // error recovery page flag byte
    localparam int F_REALLOC = 7;
    localparam int F_CONT = 4;
    localparam int F_PER = 2;
    localparam int F_NOFIX = 0;
    localparam logic [7:0] ERR_FLAG_MASK = 8'h95;
    localparam logic [7:0] ERR_FLAG_DEF = 8'h80;
    localparam logic [7:0] RRC_DEF = 8'h1F;
    localparam logic [7:0] RRC_FLOOR = 8'h03;
    localparam logic [7:0] RRC_SUB = 8'h04;
    localparam logic [7:0] WRC_FIXED = 8'h03;
    // sense keys
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_RECOVERED = 4'h1;
    localparam logic [3:0] SK_MEDIUM = 4'h3;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [3:0] ECC_RECOV_MIN = 4'h7;
    localparam logic [3:0] ECC_RECOV_MAX = 4'h8;
    localparam logic [2:0] DMI_ONE_FAIL = 3'h1;
    // flexible-disk page values, none changeable
    localparam logic [15:0] FLEX_RATE_KBPS = 16'h3E80;
    localparam logic [7:0] FLEX_HEADS = 8'h40;
    localparam logic [7:0] FLEX_SPT = 8'h20;
    localparam logic [15:0] BPS_SMALL = 16'h0200;
    localparam logic [15:0] BPS_LARGE = 16'h0800;
    localparam int CYL_SHIFT = 11;
    localparam logic [7:0] MOTOR_DEF = 8'hFF;
    localparam logic [7:0] MOTOR_NEVER = 8'hFF;
    typedef enum logic [1:0] {CS_IDLE, CS_FETCH, CS_DONE} cmd_state_t;
endpackage
`default_nettype wire

// ---- param_buf.sv ----
/*
  Byte buffer holding a transferred mode parameter list.
  Assumes one writer and one reader on the same clock; read data one cycle late.
*/
`timescale 1ns/1ps
`default_nettype none
module param_buf #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ---- recovery_judge.sv ----
/*
  Turns drive error events into a completion status and sense key,
  following the current error recovery flags.
  Assumes event strobes are one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module recovery_judge
    import odd_mode_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] flags,
    input wire logic ecc_event,
    input wire logic [3:0] ecc_bytes,
    input wire logic uncorr_event,
    input wire logic defect_event,
    input wire logic dmi_event,
    input wire logic [2:0] dmi_fail,
    output logic ev_done,
    output logic ev_check,
    output logic [3:0] ev_sense
);
    logic next_done, next_check;
    logic [3:0] next_sense;
    logic recov;

    always_comb begin
        next_done = 1'b0;
        next_check = ev_check;
        next_sense = ev_sense;
        recov = 1'b0;
        if (dmi_event) begin
            next_done = 1'b1;
            next_check = (dmi_fail != 3'h0); // R6
            next_sense = (dmi_fail == 3'h0) ? SK_NONE : (dmi_fail == DMI_ONE_FAIL) ? SK_RECOVERED : SK_MEDIUM; // R6
        end else if (uncorr_event || (ecc_event && flags[F_NOFIX])) begin
            // uncorrected data: either transfer it or fail the read
            next_done = 1'b1;
            next_check = !flags[F_CONT]; // R2 R7
            next_sense = flags[F_CONT] ? SK_NONE : SK_MEDIUM; // R2
        end else if (ecc_event) begin
            next_done = 1'b1;
            recov = (ecc_bytes >= ECC_RECOV_MIN) && (ecc_bytes <= ECC_RECOV_MAX); // R4
        end else if (defect_event) begin
            next_done = 1'b1;
            recov = flags[F_REALLOC]; // R5 R1
            next_check = !flags[F_REALLOC];
            next_sense = flags[F_REALLOC] ? SK_NONE : SK_MEDIUM;
        end
        if (next_done && (ecc_event || defect_event) && !dmi_event && !uncorr_event && !flags[F_NOFIX] ||
            next_done && defect_event && !dmi_event && !uncorr_event && !ecc_event) begin
            if (recov) begin
                next_check = flags[F_PER]; // R3
                next_sense = flags[F_PER] ? SK_RECOVERED : SK_NONE;
            end else if (ecc_event) begin
                next_check = 1'b0;
                next_sense = SK_NONE;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ev_done <= 1'b0;
            ev_check <= 1'b0;
            ev_sense <= SK_NONE;
        end else begin
            ev_done <= next_done;
            ev_check <= next_check;
            ev_sense <= next_sense;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_uncorr_report: assert property (uncorr_event && !dmi_event && !flags[F_CONT] // R2
        |=> ev_done && ev_check && ev_sense == SK_MEDIUM) else $error("uncorrectable read not failed");
    a_ecc_recovered: assert property (ecc_event && !dmi_event && !uncorr_event && !flags[F_NOFIX] // R4
        && ecc_bytes >= 4'h7 && ecc_bytes <= 4'h8
        |=> ev_check == $past(flags[F_PER]) && ev_sense == ($past(flags[F_PER]) ? SK_RECOVERED : SK_NONE))
        else $error("ecc 7-8 bytes not handled as recovered");
    a_dmi_medium: assert property (dmi_event && dmi_fail >= 3'h2 // R6
        |=> ev_check && ev_sense == SK_MEDIUM) else $error("multi-copy dmi failure not medium error");
    a_defect_realloc: assert property (defect_event && !dmi_event && !uncorr_event && !ecc_event // R5
        && flags[F_REALLOC] && flags[F_PER] |=> ev_check && ev_sense == SK_RECOVERED)
        else $error("reallocated defect not recovered");
    c_dmi_single: cover property (dmi_event && dmi_fail == 3'h1 ##1 ev_sense == SK_RECOVERED);
endmodule
`default_nettype wire

// ---- odd_mode_pages.sv ----
/*
  Mode page logic for the error recovery page and the flexible-disk page,
  reached over an Avalon-MM slave with waitrequest.
  Assumes the bus master, the drive event sources and the flash saver share clock.
*/
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: auto_realloc_on_write clear stops write reallocation; set reassigns defective blocks.
// R2: read_continue_on_error clear fails uncorrectable reads; set transfers data, ends normally.
// R3: recovered errors give good status unless post-error bit asks for recovered sense; code always gives check condition for one bad management copy.
// R4: ECC fixing seven or eight bytes per interleave is a recovered error.
// R5: a defective sector replaced during write is a recovered error.
// R6: one bad management copy of four is recovered; two or more is medium error.
// R7: correction_disable set skips correction even of correctable errors.
// R8: read retry count three or less becomes four, reported as recovered error.
// R9: any write retry count except three becomes three, reported as recovered.
// R10: host should keep the error recovery page at defaults outside diagnostics.
// R11: error recovery page is savable to nonvolatile storage.
// R12: only four flag bits and both retry bytes may change; the rest fixed.
// R13: defaults: read retry 1Fh, write retry 03h, reserved bytes zero.
// R14: flexible-disk page has no changeable bits; host writes leave it untouched.
// R15: flexible page transfer rate is in kbit/s, rotation rate in rpm.
// R16: bytes per sector reports block length, 200h or 800h.
// R17: motor off delay sets spin-down time; FFh means never stop.
// R18: heads, sectors and cylinders are logical values, not physical geometry.
// R19: host drivers should not rely on the flexible-disk page.
// R20: save_params set stores all savable transferred values to flash.
// R21: too few parameter bytes ends mode select with check condition.
// R22: host must set page_format_flag; clear gives check condition; code gives good status for a zero-length list even when clear.
// R23: error page is code 01h length 0Ah; flexible page code 05h length 1Eh.
// R24: clamped retry counts are stored as current values and read back.
module odd_mode_pages
    import odd_mode_pkg::*;
#(
    parameter logic [15:0] ROT_RATE = 16'h0E10,
    parameter int BUF_DEPTH = 64
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic media_large_block,
    input wire logic [31:0] media_lba_count,
    input wire logic ecc_event,
    input wire logic [3:0] ecc_bytes,
    input wire logic uncorr_event,
    input wire logic defect_event,
    input wire logic dmi_event,
    input wire logic [2:0] dmi_fail,
    output logic realloc_enable,
    output logic transfer_on_error,
    output logic correction_enable,
    output logic motor_never_stop,
    output logic save_strobe,
    output logic [23:0] save_image,
    output logic ev_done,
    output logic ev_check,
    output logic [3:0] ev_sense
);
    localparam int AW = $clog2(BUF_DEPTH);

    logic ack, next_ack, bus_req, wr_go;
    logic [31:0] next_readdata;
    cmd_state_t state, next_state;
    logic [7:0] idx, next_idx, fidx, next_fidx, len_q, next_len, fetch_end;
    logic fetched, next_fetched, fmt, next_fmt, sav, next_sav, hdr_bad, next_hdr_bad;
    logic [5:0] code, next_code;
    logic [7:0] plen, next_plen, sflags, next_sflags, srrc, next_srrc, swrc, next_swrc;
    logic [7:0] cur_flags, next_flags, cur_rrc, next_rrc, cur_wrc, next_wrc;
    logic cmd_check, next_check, next_save, next_motor, clamped, go, buf_wr;
    logic [3:0] cmd_sense, next_sense;
    logic [8:0] need;
    logic [7:0] rd_data;
    logic [15:0] cylinders;

    // single-cycle wait, then answer: every access takes exactly two edges
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack;
    assign wr_go = avs_write & ack;
    assign go = wr_go && avs_address == A_CMD && avs_writedata[CMD_GO_BIT] && state == CS_IDLE;
    // buffer is frozen while a command walks it
    assign buf_wr = wr_go && avs_address == A_BUF && state == CS_IDLE;
    assign cylinders = media_lba_count[CYL_SHIFT +: 16]; // R18

    always_comb begin
        next_ack = bus_req & ~ack;
        next_readdata = avs_readdata;
        if (avs_read && !ack) begin
            unique case (avs_address)
                A_STAT: next_readdata = {24'h0, cmd_sense, 2'b00, cmd_check, state != CS_IDLE};
                A_ERRPG: next_readdata = {8'h00, cur_wrc, cur_rrc, cur_flags}; // R24
                A_FLEX0: next_readdata = {FLEX_RATE_KBPS, FLEX_HEADS, FLEX_SPT}; // R15 R18
                A_FLEX1: next_readdata = {media_large_block ? BPS_LARGE : BPS_SMALL, cylinders}; // R16
                A_FLEX2: next_readdata = {ROT_RATE, 8'h00, MOTOR_DEF}; // R15 R17
                A_EVST: next_readdata = {27'h0, ev_check, ev_sense};
                default: next_readdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack <= next_ack;
            avs_readdata <= next_readdata;
        end
    end

    param_buf #(.DEPTH(BUF_DEPTH), .AW(AW)) u_buf (
        .clock(clock),
        .wr_en(buf_wr),
        .wr_addr(avs_writedata[BUF_IDX_LSB +: AW]),
        .wr_data(avs_writedata[7:0]),
        .rd_addr(idx[AW-1:0]),
        .rd_data(rd_data)
    );

    assign fetch_end = (len_q > FETCH_MAX) ? FETCH_MAX : len_q;
    assign need = {1'b0, B_PARAM} + {1'b0, plen};

    always_comb begin
        next_state = state;
        next_idx = idx;
        next_fidx = idx;
        next_fetched = 1'b0;
        next_len = len_q;
        next_fmt = fmt;
        next_sav = sav;
        next_hdr_bad = hdr_bad;
        next_code = code;
        next_plen = plen;
        next_sflags = sflags;
        next_srrc = srrc;
        next_swrc = swrc;
        next_flags = cur_flags;
        next_rrc = cur_rrc;
        next_wrc = cur_wrc;
        next_check = cmd_check;
        next_sense = cmd_sense;
        next_save = 1'b0;
        next_motor = (MOTOR_DEF == MOTOR_NEVER); // R17
        clamped = 1'b0;
        if (fetched) begin
            case (fidx)
                B_MDL0, B_MDL1: next_hdr_bad = hdr_bad | (rd_data != 8'h00);
                B_CODE: next_code = rd_data[5:0];
                B_PLEN: next_plen = rd_data;
                B_FLAGS: next_sflags = rd_data;
                B_RRC: next_srrc = rd_data;
                B_WRC: next_swrc = rd_data;
                default: next_code = code;
            endcase
        end
        unique case (state)
            CS_IDLE: begin
                if (go) begin
                    next_state = CS_FETCH;
                    next_idx = 8'h00;
                    next_len = avs_writedata[CMD_LEN_LSB +: 8];
                    next_fmt = avs_writedata[CMD_FMT_BIT];
                    next_sav = avs_writedata[CMD_SAV_BIT];
                    next_hdr_bad = 1'b0;
                    next_code = 6'h00;
                    next_plen = 8'h00;
                    next_sflags = cur_flags;
                    next_srrc = cur_rrc;
                    next_swrc = cur_wrc;
                end
            end
            CS_FETCH: begin
                if (idx == fetch_end) begin
                    next_state = CS_DONE;
                end else begin
                    next_idx = 8'(idx + 8'h01);
                    next_fetched = 1'b1;
                end
            end
            CS_DONE: begin
                next_state = CS_IDLE;
                next_check = 1'b1;
                next_sense = SK_ILLEGAL;
                if (len_q == 8'h00) begin
                    next_check = 1'b0;
                    next_sense = SK_NONE;
                end else if (!fmt) begin
                    next_check = 1'b1; // R22
                end else if (len_q < B_PARAM || hdr_bad || {1'b0, len_q} < need) begin
                    next_check = 1'b1; // R21
                end else if (code == PG_ERR && plen == PG_ERR_LEN) begin // R23
                    next_flags = (cur_flags & ~ERR_FLAG_MASK) | (sflags & ERR_FLAG_MASK); // R12
                    next_rrc = srrc;
                    next_wrc = swrc;
                    if (srrc <= RRC_FLOOR) begin
                        next_rrc = RRC_SUB; // R8 R24
                        clamped = 1'b1;
                    end
                    if (swrc != WRC_FIXED) begin
                        next_wrc = WRC_FIXED; // R9 R24
                        clamped = 1'b1;
                    end
                    next_check = clamped;
                    next_sense = clamped ? SK_RECOVERED : SK_NONE;
                    next_save = sav; // R11 R20
                end else if (code == PG_FLEX && plen == PG_FLEX_LEN) begin // R23
                    next_check = 1'b0; // R14
                    next_sense = SK_NONE;
                    next_save = sav; // R20
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= CS_IDLE;
            idx <= 8'h00;
            fidx <= 8'h00;
            fetched <= 1'b0;
            len_q <= 8'h00;
            fmt <= 1'b0;
            sav <= 1'b0;
            hdr_bad <= 1'b0;
            code <= 6'h00;
            plen <= 8'h00;
            sflags <= ERR_FLAG_DEF;
            srrc <= RRC_DEF;
            swrc <= WRC_FIXED;
            cur_flags <= ERR_FLAG_DEF; // R13
            cur_rrc <= RRC_DEF; // R13
            cur_wrc <= WRC_FIXED; // R13
            cmd_check <= 1'b0;
            cmd_sense <= SK_NONE;
            save_strobe <= 1'b0;
            motor_never_stop <= (MOTOR_DEF == MOTOR_NEVER);
        end else begin
            state <= next_state;
            idx <= next_idx;
            fidx <= next_fidx;
            fetched <= next_fetched;
            len_q <= next_len;
            fmt <= next_fmt;
            sav <= next_sav;
            hdr_bad <= next_hdr_bad;
            code <= next_code;
            plen <= next_plen;
            sflags <= next_sflags;
            srrc <= next_srrc;
            swrc <= next_swrc;
            cur_flags <= next_flags;
            cur_rrc <= next_rrc;
            cur_wrc <= next_wrc;
            cmd_check <= next_check;
            cmd_sense <= next_sense;
            save_strobe <= next_save;
            motor_never_stop <= next_motor;
        end
    end

    assign save_image = {cur_wrc, cur_rrc, cur_flags}; // R11
    assign realloc_enable = cur_flags[F_REALLOC]; // R1
    assign transfer_on_error = cur_flags[F_CONT]; // R2
    assign correction_enable = ~cur_flags[F_NOFIX]; // R7

    recovery_judge u_judge (
        .clock(clock),
        .rst_b(rst_b),
        .flags(cur_flags),
        .ecc_event(ecc_event),
        .ecc_bytes(ecc_bytes),
        .uncorr_event(uncorr_event),
        .defect_event(defect_event),
        .dmi_event(dmi_event),
        .dmi_fail(dmi_fail),
        .ev_done(ev_done),
        .ev_check(ev_check),
        .ev_sense(ev_sense)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_rrc_floor: assert property (cur_rrc > 8'h03) else $error("read retry count below four"); // R8
    a_wrc_fixed: assert property (cur_wrc == 8'h03) else $error("write retry count not three"); // R9
    a_fixed_bits: assert property ((cur_flags & 8'h6A) == 8'h00) else $error("fixed flag bit changed"); // R12
    a_fmt_refused: assert property (state == CS_DONE && len_q != 8'h00 && !fmt // R22
        |=> cmd_check && cmd_sense == SK_ILLEGAL && $stable(cur_rrc)) else $error("missing page format not refused");
    a_short_list: assert property (state == CS_DONE && fmt && len_q != 8'h00 && len_q < 8'h0A // R21
        |=> cmd_check && cmd_sense == SK_ILLEGAL && !save_strobe) else $error("short list not refused");
    a_save_cause: assert property (save_strobe |-> $past(state) == CS_DONE && $past(sav) ##1 !save_strobe) // R20
        else $error("save strobe without saving command");
    a_clamp_report: assert property (state == CS_DONE && fmt && code == 6'h01 && plen == 8'h0A && !hdr_bad // R8
        && len_q >= 8'h14 && srrc <= 8'h03 |=> cur_rrc == 8'h04 && cmd_check && cmd_sense == SK_RECOVERED)
        else $error("low read retry count not substituted");
    c_err_page_ok: cover property (state == CS_DONE && code == PG_ERR ##1 !cmd_check);
    c_flex_page: cover property (state == CS_DONE && code == PG_FLEX && fmt);
    c_save: cover property (save_strobe);
endmodule
`default_nettype wire

// ---- host_bus_model.sv ----
/*
  Host side model: an Avalon-MM master that issues register accesses and mode select commands.
  Assumes the shared clock and a slave that answers by dropping waitrequest.
*/
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
    import odd_mode_pkg::*;
(
    input wire logic clock,
    output var logic [4:0] avs_address,
    output var logic avs_read,
    output var logic avs_write,
    output var logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
    end

    // waitrequest and read data are taken at the rising edge that ends the wait
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        ok = 1'b0;
        q = 32'h00000000;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge clock);
            ok = (avs_waitrequest === 1'b0);
            q = avs_readdata;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // host leaves pages alone except for deliberate diagnostics
    task automatic mode_select(input logic [7:0] len, input logic fmt, input logic sav,
                               output logic [31:0] st, output logic ok);
        xfer(1'b1, A_CMD, {16'h0000, len, 5'h00, sav, fmt, 1'b1}, st, ok);
        st = 32'h00000001;
        for (int i = 0; i < 64 && ok && st[0] !== 1'b0; i++) begin
            xfer(1'b0, A_STAT, 32'h00000000, st, ok);
        end
        ok = ok && (st[0] === 1'b0);
    endtask
endmodule
`default_nettype wire

// ---- error_recovery_mode_page_logic_tb_top.sv ----
/*
  Self-checking bench for the mode page block, one task per scenario.
  Assumes the host model drives the register bus and the bench drives drive events.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module error_recovery_mode_page_logic_tb_top
    import odd_mode_pkg::*;
;
    logic clock, rst_b, media_large_block, ecc_event, uncorr_event, defect_event, dmi_event;
    logic [31:0] media_lba_count, avs_writedata, avs_readdata, q;
    logic [4:0] avs_address;
    logic [3:0] ecc_bytes, ev_sense;
    logic [2:0] dmi_fail;
    logic avs_read, avs_write, avs_waitrequest, realloc_enable, transfer_on_error, correction_enable;
    logic motor_never_stop, save_strobe, ev_done, ev_check;
    logic [23:0] save_image, img;
    int miscompares, comparisons, saves;

    odd_mode_pages i_dut (.clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .media_large_block(media_large_block),
        .media_lba_count(media_lba_count), .ecc_event(ecc_event), .ecc_bytes(ecc_bytes),
        .uncorr_event(uncorr_event), .defect_event(defect_event), .dmi_event(dmi_event),
        .dmi_fail(dmi_fail), .realloc_enable(realloc_enable), .transfer_on_error(transfer_on_error),
        .correction_enable(correction_enable), .motor_never_stop(motor_never_stop),
        .save_strobe(save_strobe), .save_image(save_image), .ev_done(ev_done), .ev_check(ev_check),
        .ev_sense(ev_sense));
    host_bus_model i_host (.clock(clock), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    always #50 clock = ~clock;
    always @(posedge clock) begin
        if (save_strobe === 1'b1) begin
            saves++;
            img <= save_image;
        end
    end

    task automatic final_report;
        if (miscompares == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        logic ok;
        i_host.xfer(wr, a, d, q, ok);
        if (!ok) begin miscompares++; final_report; end
    endtask
    task automatic ms(input logic [7:0] len, input logic fmt, input logic sav, input logic [7:0] st);
        logic ok;
        i_host.mode_select(len, fmt, sav, q, ok);
        if (!ok) begin miscompares++; final_report; end
        `CHK("status", st, q[7:0])
    endtask
    task automatic fill(input logic [7:0] c, p, f, r, w, input int n);
        for (int i = 0; i < n; i++) begin
            bus(1'b1, A_BUF, {18'h0, 6'(i), (i == 8) ? c : (i == 9) ? p : (i == 10) ? f :
                (i == 11) ? r : (i == 16) ? w : 8'h00});
        end
    endtask
    task automatic ev(input int k, input logic [3:0] n, input logic [4:0] exp);
        @(posedge clock);
        {ecc_event, uncorr_event, defect_event, dmi_event} <= 4'h8 >> k;
        ecc_bytes <= n;
        dmi_fail <= n[2:0];
        @(posedge clock);
        {ecc_event, uncorr_event, defect_event, dmi_event} <= 4'h0;
        @(negedge clock);
        `CHK("ev_done", 1'b1, ev_done)
        `CHK("ev_status", exp, {ev_check, ev_sense})
    endtask

    task automatic t_defaults;
        bus(1'b0, A_ERRPG, 32'h0); `CHK("errpg", 32'h00031F80, q)
        `CHK("realloc", 1'b1, realloc_enable)
        `CHK("xfer_err", 1'b0, transfer_on_error)
        `CHK("correct", 1'b1, correction_enable)
        `CHK("motor", 1'b1, motor_never_stop)
        bus(1'b0, A_FLEX0, 32'h0); `CHK("flex0", 32'h3E804020, q)
        bus(1'b0, A_FLEX1, 32'h0); `CHK("flex1", 32'h02000271, q)
        media_large_block <= 1'b1;
        bus(1'b0, A_FLEX1, 32'h0); `CHK("flex1", 32'h08000271, q)
        bus(1'b0, A_FLEX2, 32'h0); `CHK("flex2", 8'hFF, q[7:0])
    endtask
    task automatic t_refuse;
        fill(8'h01, 8'h0A, 8'hFF, 8'h00, 8'h00, 20);
        ms(8'd20, 1'b0, 1'b0, 8'h52);
        ms(8'd9, 1'b1, 1'b0, 8'h52);
        fill(8'h05, 8'h1E, 8'hFF, 8'hFF, 8'hFF, 40);
        ms(8'd40, 1'b1, 1'b0, 8'h00);
        bus(1'b0, A_ERRPG, 32'h0); `CHK("errpg", 32'h00031F80, q)
    endtask
    task automatic t_events;
        ev(0, 4'h7, 5'h00);
        ev(3, 4'h1, 5'h11);
        ev(3, 4'h2, 5'h13);
        ev(3, 4'h4, 5'h13);
        ev(1, 4'h0, 5'h13);
        fill(8'h01, 8'h0A, 8'h84, 8'h1F, 8'h03, 20);
        ms(8'd20, 1'b1, 1'b0, 8'h00);
        ev(0, 4'h8, 5'h11);
        ev(2, 4'h0, 5'h11);
    endtask
    task automatic t_clamp;
        fill(8'h01, 8'h0A, 8'hFF, 8'h03, 8'h00, 20);
        ms(8'd20, 1'b1, 1'b1, 8'h12);
        bus(1'b0, A_ERRPG, 32'h0); `CHK("errpg", 32'h00030495, q)
        `CHK("saves", 1, saves)
        `CHK("image", 24'h030495, img)
        `CHK("xfer_err", 1'b1, transfer_on_error)
        `CHK("correct", 1'b0, correction_enable)
        ev(0, 4'h7, 5'h00);
        fill(8'h01, 8'h0A, 8'h00, 8'h04, 8'h03, 20);
        ms(8'd20, 1'b1, 1'b0, 8'h00);
        bus(1'b0, A_ERRPG, 32'h0); `CHK("errpg", 32'h00030400, q)
        `CHK("realloc", 1'b0, realloc_enable)
        ev(2, 4'h0, 5'h13);
        bus(1'b0, A_EVST, 32'h0); `CHK("evst", 32'h00000013, q)
    endtask

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        media_large_block = 1'b0;
        media_lba_count = 32'h00138800;
        {ecc_event, uncorr_event, defect_event, dmi_event} = 4'h0;
        ecc_bytes = 4'h0;
        dmi_fail = 3'h0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        t_defaults;
        t_refuse;
        t_events;
        t_clamp;
        final_report;
    end
endmodule
`default_nettype wire
